// File: data_cache_bus_request_sequencer_tb.sv
`timescale 1ns/1ps
module data_cache_bus_request_sequencer_tb;
	logic         mclk_i;
	logic         rst_n_i;
	logic [1:0]   ratio;
	logic         core_rst;
	logic         acc_valid, acc_write, acc_line, acc_ready, rd_done;
	logic [31:0]  acc_addr, acc_wdata, rd_word;
	logic [3:0]   acc_be;
	logic         flush_valid, flush_ready, cache_wr, mem_wr_valid, mem_rd_valid;
	logic [31:0]  flush_addr, cache_addr, mem_wr_addr, mem_wr_data, mem_rd_addr;
	logic [255:0] flush_line;
	logic [1:0]   cache_chunk;
	logic [95:0]  cache_data;
	logic [3:0]   mem_wr_be;
	logic [97:0]  wq[$], fd[$];
	int           wc[$], ft[$], wt[$];
	int           cyc, nrd, fails, checks_done;

	dcbrs_if bus_if ();
	dcbrs_dcu_end dcbrs_dcu_end_inst (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
		.acc_valid_i(acc_valid), .acc_write_i(acc_write), .acc_line_i(acc_line),
		.acc_addr_i(acc_addr), .acc_be_i(acc_be), .acc_wdata_i(acc_wdata),
		.acc_ready_o(acc_ready), .rd_done_o(rd_done), .rd_word_o(rd_word),
		.flush_valid_i(flush_valid), .flush_addr_i(flush_addr), .flush_line_i(flush_line),
		.flush_ready_o(flush_ready), .cache_wr_o(cache_wr), .cache_chunk_o(cache_chunk),
		.cache_addr_o(cache_addr), .cache_data_o(cache_data), .core_reset_i(core_rst),
		.bus_if(bus_if));
	dcbrs_biu_end dcbrs_biu_end_inst (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .bus_ratio_i(ratio),
		.bus_if(bus_if), .mem_wr_valid_o(mem_wr_valid), .mem_wr_addr_o(mem_wr_addr),
		.mem_wr_data_o(mem_wr_data), .mem_wr_be_o(mem_wr_be), .mem_rd_valid_o(mem_rd_valid),
		.mem_rd_addr_o(mem_rd_addr), .mem_rd_data_i(~mem_rd_addr));
	dcbrs_sva dcbrs_sva_inst (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .bus_en(bus_if.bus_en),
		.rd_req(bus_if.rd_req), .rd_line(bus_if.rd_line), .abort(bus_if.abort),
		.rd_dval(bus_if.rd_dval), .wr_req(bus_if.wr_req), .wr_line(bus_if.wr_line),
		.wr_addr(bus_if.wr_addr));

	initial begin
		mclk_i = 1'b0;
		forever #12.5 mclk_i = ~mclk_i;
	end

	always @(posedge mclk_i) begin
		cyc <= cyc + 1;
		if (mem_wr_valid === 1'b1) wq.push_back({30'h0, mem_wr_be, mem_wr_addr, mem_wr_data});
		if (mem_wr_valid === 1'b1) wc.push_back(cyc);
		if (cache_wr === 1'b1) fd.push_back({cache_chunk, cache_data});
		if (cache_wr === 1'b1) ft.push_back(cyc);
		if (bus_if.bus_en === 1'b1 && bus_if.wr_req === 1'b1) wt.push_back(cyc);
		if (bus_if.bus_en === 1'b1 && bus_if.rd_dval === 1'b1) nrd <= nrd + 1;
		// nothing should take this long
		if (cyc == 20000) begin
			fails++;
			final_report();
		end
	end

	task automatic check(input logic [97:0] got, input logic [97:0] exp);
		checks_done++;
		if (got !== exp) begin
			fails++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check

	task automatic checki(input int got, input int exp);
		check(98'(got), 98'(exp));
	endtask : checki

	task automatic final_report();
		if (fails == 0 && checks_done > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : final_report

	function automatic logic [31:0] lw(input int k);
		return 32'h11111111 * 32'(k + 1);
	endfunction : lw

	// memory answers the inverted address
	function automatic logic [97:0] chunk(input logic [31:0] b, input int k);
		logic [97:0] c;
		c = {k[1:0], 96'h0};
		for (int i = 0; i < 3; i++)
			if (3 * k + i < 8) c[32 * i +: 32] = ~{b[31:5], 3'(3 * k + i), 2'h0};
		return c;
	endfunction : chunk

	task automatic clr();
		wq.delete();
		wc.delete();
		fd.delete();
		ft.delete();
		wt.delete();
		nrd = 0;
	endtask : clr

	task automatic do_reset(input logic [1:0] r);
		@(posedge mclk_i);
		rst_n_i <= 1'b0;
		ratio <= r;
		repeat (10) @(posedge mclk_i);
		rst_n_i <= 1'b1;
		@(posedge mclk_i);
	endtask : do_reset

	task automatic access(input logic w, input logic l, input logic [31:0] a,
		input logic [3:0] be, input logic [31:0] d);
		@(posedge mclk_i);
		acc_valid <= 1'b1;
		acc_write <= w;
		acc_line <= l;
		acc_addr <= a;
		acc_be <= be;
		acc_wdata <= d;
		do @(posedge mclk_i); while (acc_ready !== 1'b1);
		acc_valid <= 1'b0;
	endtask : access

	task automatic flush(input logic [31:0] a, output int t);
		@(posedge mclk_i);
		flush_valid <= 1'b1;
		flush_addr <= a;
		do @(posedge mclk_i); while (flush_ready !== 1'b1);
		t = cyc;
		flush_valid <= 1'b0;
	endtask : flush

	task automatic wait_wr(input int n);
		while (wq.size() < n) @(posedge mclk_i);
	endtask : wait_wr

	task automatic wait_fill(input logic [31:0] b);
		while (fd.size() < 3) @(posedge mclk_i);
		for (int k = 0; k < 3; k++) check(fd[k], chunk(b, k));
		checki(ft[2] - ft[0], 2);
		check(98'(cache_addr), 98'(b));
	endtask : wait_fill

	task automatic read_word(input logic [31:0] a, input logic [3:0] be, input logic [31:0] m);
		access(1'b0, 1'b0, a, be, 32'h0);
		do @(posedge mclk_i); while (rd_done !== 1'b1);
		check(98'(rd_word), 98'(~a & m));
	endtask : read_word

	task automatic chk_line(input logic [31:0] b, input int s, input int r);
		for (int k = 0; k < 8; k++) begin
			check(wq[s + k], {30'h0, 4'hf, b + 32'(4 * k), lw(k)});
			if (k > 0) checki(wc[s + k] - wc[s + k - 1], r);
		end
	endtask : chk_line

	// line write, pipelined line read, then a word write
	task automatic t_pipe();
		int t;
		clr();
		flush(32'h00001000, t);
		access(1'b0, 1'b1, 32'h00002000, 4'hf, 32'h0);
		access(1'b1, 1'b0, 32'h00003004, 4'h3, 32'h0badf00d);
		wait_wr(9);
		chk_line(32'h00001000, 0, 1);
		check(wq[8], {30'h0, 4'h3, 32'h00003004, 32'h0badf00d});
		checki(wt[0] - t, 4);
		wait_fill(32'h00002000);
	endtask : t_pipe

	// word write, word reads, word write, line read
	task automatic t_single();
		clr();
		access(1'b1, 1'b0, 32'h00004008, 4'h1, 32'h12345678);
		read_word(32'h00005010, 4'h6, 32'h00ffff00);
		read_word(32'h00005014, 4'h9, 32'hff0000ff);
		access(1'b1, 1'b0, 32'h0000400c, 4'hc, 32'h9abcdef0);
		access(1'b0, 1'b1, 32'h00006000, 4'hf, 32'h0);
		wait_fill(32'h00006000);
		check(wq[0], {30'h0, 4'h1, 32'h00004008, 32'h12345678});
		check(wq[1], {30'h0, 4'hc, 32'h0000400c, 32'h9abcdef0});
	endtask : t_single

	task automatic t_depth();
		int t0, t1, t2;
		clr();
		flush(32'h00007000, t0);
		flush(32'h00008000, t1);
		#1 check(98'(flush_ready), 98'(0));
		flush(32'h00009000, t2);
		wait_wr(24);
		check(98'(t2 >= wc[7]), 98'(1));
		chk_line(32'h00007000, 0, 1);
		chk_line(32'h00008000, 8, 1);
		chk_line(32'h00009000, 16, 1);
	endtask : t_depth

	// core reset lands while a read is on the link at a 3:1 bus
	task automatic t_abort();
		int t;
		clr();
		flush(32'h0000a000, t);
		access(1'b0, 1'b1, 32'h0000b000, 4'hf, 32'h0);
		do @(posedge mclk_i); while (bus_if.rd_req !== 1'b1);
		core_rst <= 1'b1;
		wait_wr(8);
		repeat (30) @(posedge mclk_i);
		checki(nrd, 0);
		checki(fd.size(), 0);
		chk_line(32'h0000a000, 0, 3);
		core_rst <= 1'b0;
	endtask : t_abort

	task automatic t_slow_read();
		clr();
		access(1'b0, 1'b1, 32'h0000c000, 4'hf, 32'h0);
		wait_fill(32'h0000c000);
		checki(nrd, 8);
		check(98'(mem_rd_valid), 98'(0));
	endtask : t_slow_read

	initial begin
		rst_n_i = 1'b0;
		ratio = 2'h1;
		core_rst = 1'b0;
		acc_valid = 1'b0;
		acc_write = 1'b0;
		acc_line = 1'b0;
		acc_addr = 32'h0;
		acc_be = 4'h0;
		acc_wdata = 32'h0;
		flush_valid = 1'b0;
		flush_addr = 32'h0;
		cyc = 0;
		nrd = 0;
		fails = 0;
		checks_done = 0;
		for (int k = 0; k < 8; k++) flush_line[32 * k +: 32] = lw(k);
		do_reset(2'h1);
		t_pipe();
		t_single();
		t_depth();
		do_reset(2'h3);
		t_abort();
		do_reset(2'h2);
		t_slow_read();
		final_report();
	end
endmodule : data_cache_bus_request_sequencer_tb

// File: dcbrs_biu_end.sv
`timescale 1ns/1ps
module dcbrs_biu_end (
	// clock and reset
	input  wire logic                             mclk_i,
	input  wire logic                             rst_n_i,
	// bus rate: core cycles per bus cycle
	input  wire logic [dcbrs_pkg::RATIO_W-1:0]    bus_ratio_i,
	// link to the cache unit
	dcbrs_if.biu                                  bus_if,
	// memory write side
	output logic                                  mem_wr_valid_o,
	output logic [dcbrs_pkg::WORD_W-1:0]          mem_wr_addr_o,
	output logic [dcbrs_pkg::WORD_W-1:0]          mem_wr_data_o,
	output logic [dcbrs_pkg::BE_W-1:0]            mem_wr_be_o,
	// memory read side
	output logic                                  mem_rd_valid_o,
	output logic [dcbrs_pkg::WORD_W-1:0]          mem_rd_addr_o,
	input  wire logic [dcbrs_pkg::WORD_W-1:0]     mem_rd_data_i
);
	localparam int LW = dcbrs_pkg::LINE_WORDS;
	localparam int OW = dcbrs_pkg::LINE_OFS_W;

	logic [dcbrs_pkg::RATIO_W-1:0] div_q;
	logic [dcbrs_pkg::RATIO_W-1:0] div_lim;
	logic                          bus_en_q;
	logic                          w_act_q;
	logic [2:0]                    w_beat_q;
	logic [dcbrs_pkg::WORD_W-1:0]  w_base_q;
	logic                          r_act_q;
	logic                          r_line_q;
	logic [2:0]                    r_beat_q;

	assign div_lim = (bus_ratio_i == '0) ? '0 : bus_ratio_i - 2'h1;

	// one enable pulse per bus cycle
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			div_q    <= '0;
			bus_en_q <= 1'b0;
		end else begin
			bus_en_q <= (div_q >= div_lim);
			div_q    <= (div_q >= div_lim) ? '0 : div_q + 2'h1;
		end
	end

	// writes are taken at once and never dropped by abort
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			w_act_q        <= 1'b0;
			w_beat_q       <= '0;
			w_base_q       <= '0;
			mem_wr_valid_o <= 1'b0;
			mem_wr_addr_o  <= '0;
			mem_wr_data_o  <= '0;
			mem_wr_be_o    <= '0;
		end else if (bus_en_q && bus_if.wr_req) begin
			mem_wr_valid_o <= 1'b1;
			mem_wr_addr_o  <= bus_if.wr_addr;
			mem_wr_data_o  <= bus_if.wr_data;
			mem_wr_be_o    <= bus_if.wr_line ? dcbrs_pkg::BE_ALL : bus_if.wr_be;
			w_base_q       <= bus_if.wr_addr;
			w_act_q        <= bus_if.wr_line;
			w_beat_q       <= 3'h1;
		end else if (bus_en_q && w_act_q) begin
			mem_wr_valid_o <= 1'b1;
			mem_wr_addr_o  <= {w_base_q[dcbrs_pkg::WORD_W-1:OW], w_beat_q, 2'h0};
			mem_wr_data_o  <= bus_if.wr_data;
			mem_wr_be_o    <= dcbrs_pkg::BE_ALL;
			w_act_q        <= (w_beat_q != dcbrs_pkg::LAST_BEAT);
			w_beat_q       <= w_beat_q + 3'h1;
		end else begin
			mem_wr_valid_o <= 1'b0;
		end
	end

	// read beats start the bus cycle after the request
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			r_act_q       <= 1'b0;
			r_line_q      <= 1'b0;
			r_beat_q      <= '0;
			mem_rd_addr_o <= '0;
		end else if (bus_en_q && bus_if.rd_req && !bus_if.abort) begin
			r_act_q       <= 1'b1;
			r_line_q      <= bus_if.rd_line;
			r_beat_q      <= '0;
			mem_rd_addr_o <= bus_if.rd_addr;
		end else if (bus_en_q && r_act_q) begin
			if (!r_line_q || r_beat_q == dcbrs_pkg::LAST_BEAT) begin
				r_act_q <= 1'b0;
			end else begin
				r_beat_q      <= r_beat_q + 3'h1;
				mem_rd_addr_o <= {mem_rd_addr_o[dcbrs_pkg::WORD_W-1:OW],
					r_beat_q + 3'h1, 2'h0};
			end
		end
	end

	assign bus_if.bus_en   = bus_en_q;
	assign bus_if.rd_dval  = r_act_q;
	assign bus_if.rd_data  = mem_rd_data_i;
	assign mem_rd_valid_o  = r_act_q;
endmodule : dcbrs_biu_end

// File: dcbrs_dcu_end.sv
`timescale 1ns/1ps
module dcbrs_dcu_end (
	// clock and reset
	input  wire logic                              mclk_i,
	input  wire logic                              rst_n_i,
	// core access
	input  wire logic                              acc_valid_i,
	input  wire logic                              acc_write_i,
	input  wire logic                              acc_line_i,
	input  wire logic [dcbrs_pkg::WORD_W-1:0]      acc_addr_i,
	input  wire logic [dcbrs_pkg::BE_W-1:0]        acc_be_i,
	input  wire logic [dcbrs_pkg::WORD_W-1:0]      acc_wdata_i,
	output logic                                   acc_ready_o,
	output logic                                   rd_done_o,
	output logic [dcbrs_pkg::WORD_W-1:0]           rd_word_o,
	// flush
	input  wire logic                              flush_valid_i,
	input  wire logic [dcbrs_pkg::WORD_W-1:0]      flush_addr_i,
	input  wire logic [dcbrs_pkg::LINE_BITS-1:0]   flush_line_i,
	output logic                                   flush_ready_o,
	// cache fill port
	output logic                                   cache_wr_o,
	output logic [1:0]                             cache_chunk_o,
	output logic [dcbrs_pkg::WORD_W-1:0]           cache_addr_o,
	output logic [dcbrs_pkg::CHUNK_BITS-1:0]       cache_data_o,
	// core reset
	input  wire logic                              core_reset_i,
	// link to the bus unit
	dcbrs_if.dcu                                   bus_if
);
	localparam int LW = dcbrs_pkg::LINE_WORDS;
	localparam int W  = dcbrs_pkg::WORD_W;

	// strobes and pending core access
	logic         bus_en, taking, go_flush, go_wr, go_rd, rd_beat_in, rd_last;
	logic         acc_pend_q, acc_wr_q, acc_line_q;
	logic [W-1:0] acc_addr_q, acc_wdata_q, rd_addr_q, wr_addr_q, wr_data_q;
	logic [3:0]   acc_be_q, rd_be_q, wr_be_q;
	// read side
	logic         rd_req_q, rd_line_q, rd_busy_q;
	logic [2:0]   rd_beat_q, wr_beat_q;
	logic [W-1:0] fill_mem [0:LW-1];
	logic [1:0]   fill_cnt_q, fq_cnt_q, fq_cnt_d, prep_q;
	logic [dcbrs_pkg::CHUNK_BITS-1:0] chunk_d;
	// write side and flush queue
	logic         wr_req_q, wr_line_q, wr_busy_q;
	logic [W-1:0] fq_addr_q [0:1];
	logic [W-1:0] fq_data_q [0:2*LW-1];
	logic         fq_head_q, fq_iss_q, push_slot, push, pop, prep_done_q, abort_q;
	assign bus_en     = bus_if.bus_en;
	// a request is taken on the first bus edge it is seen
	assign taking     = rd_req_q | wr_req_q;
	assign go_flush   = bus_en && !taking && !wr_busy_q && prep_done_q;
	assign go_wr      = bus_en && !taking && !wr_busy_q && !go_flush && !core_reset_i
		&& acc_pend_q && acc_wr_q;
	assign go_rd      = bus_en && !taking && !rd_busy_q && fill_cnt_q == 2'h0
		&& !go_flush && !core_reset_i && acc_pend_q && !acc_wr_q;
	assign rd_beat_in = bus_en && rd_busy_q && !rd_req_q && bus_if.rd_dval;
	assign rd_last    = rd_beat_in && (!rd_line_q || rd_beat_q == dcbrs_pkg::LAST_BEAT);
	assign push       = flush_valid_i && flush_ready_o;
	assign push_slot  = fq_head_q ^ fq_cnt_q[0];
	assign pop        = bus_en && wr_busy_q && !wr_req_q && wr_line_q
		&& wr_beat_q == dcbrs_pkg::LAST_BEAT;
	assign fq_cnt_d   = fq_cnt_q + {1'b0, push} - {1'b0, pop};
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i || core_reset_i) begin
			acc_pend_q  <= 1'b0;
			acc_ready_o <= 1'b0;
		end else if (go_wr || go_rd) begin
			acc_pend_q  <= 1'b0;
			acc_ready_o <= 1'b1;
		end else if (acc_valid_i && acc_ready_o) begin
			acc_pend_q  <= 1'b1;
			acc_ready_o <= 1'b0;
			acc_wr_q    <= acc_write_i;
			acc_line_q  <= acc_line_i;
			acc_addr_q  <= acc_addr_i;
			acc_be_q    <= acc_be_i;
			acc_wdata_q <= acc_wdata_i;
		end else begin
			acc_ready_o <= !acc_pend_q;
		end
	end
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			fq_cnt_q      <= 2'h0;
			fq_head_q     <= 1'b0;
			fq_iss_q      <= 1'b0;
			flush_ready_o <= 1'b0;
		end else begin
			fq_cnt_q      <= fq_cnt_d;
			flush_ready_o <= fq_cnt_d != dcbrs_pkg::FLUSH_DEPTH;
			if (pop) begin
				fq_head_q <= ~fq_head_q;
				fq_iss_q  <= 1'b0;
			end else if (go_flush) begin
				fq_iss_q  <= 1'b1;
			end
		end
	end
	// queued line data has no reset; only valid slots are read
	always_ff @(posedge mclk_i) begin
		if (push) begin
			fq_addr_q[push_slot] <= flush_addr_i;
			for (int i = 0; i < LW; i++) begin
				fq_data_q[{push_slot, 3'(i)}] <= flush_line_i[i*W +: W];
			end
		end
	end
	// flush work on the oldest entry not yet requested
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i || go_flush) begin
			prep_q      <= 2'h0;
			prep_done_q <= 1'b0;
		end else if (fq_cnt_q > {1'b0, fq_iss_q} && !prep_done_q) begin
			prep_q      <= prep_q + 2'h1;
			prep_done_q <= (prep_q == dcbrs_pkg::FLUSH_PREP - 2'h1);
		end
	end
	// write requests and data beats
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			wr_req_q  <= 1'b0;
			wr_line_q <= 1'b0;
			wr_busy_q <= 1'b0;
			wr_addr_q <= '0;
			wr_be_q   <= 4'h0;
			wr_data_q <= '0;
			wr_beat_q <= 3'h0;
		end else if (go_flush) begin
			wr_req_q  <= 1'b1;
			wr_line_q <= 1'b1;
			wr_busy_q <= 1'b1;
			wr_addr_q <= fq_addr_q[fq_head_q];
			wr_be_q   <= dcbrs_pkg::BE_ALL;
			wr_data_q <= fq_data_q[{fq_head_q, 3'h0}];
			wr_beat_q <= 3'h0;
		end else if (go_wr) begin
			wr_req_q  <= 1'b1;
			wr_line_q <= 1'b0;
			wr_busy_q <= 1'b1;
			wr_addr_q <= acc_addr_q;
			wr_be_q   <= acc_be_q;
			wr_data_q <= acc_wdata_q;
			wr_beat_q <= 3'h0;
		end else if (bus_en && wr_busy_q) begin
			// beat taken; a core reset does not stop it
			wr_req_q <= 1'b0;
			if (!wr_line_q || wr_beat_q == dcbrs_pkg::LAST_BEAT) begin
				wr_busy_q <= 1'b0;
			end else begin
				wr_beat_q <= wr_beat_q + 3'h1;
				wr_data_q <= fq_data_q[{fq_head_q, wr_beat_q + 3'h1}];
			end
		end
	end
	// read requests and tracking
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			rd_req_q  <= 1'b0;
			rd_line_q <= 1'b0;
			rd_busy_q <= 1'b0;
			rd_addr_q <= '0;
			rd_be_q   <= 4'h0;
			rd_beat_q <= 3'h0;
		end else if (go_rd) begin
			rd_req_q  <= 1'b1;
			rd_line_q <= acc_line_q;
			rd_busy_q <= 1'b1;
			rd_addr_q <= acc_addr_q;
			rd_be_q   <= acc_line_q ? dcbrs_pkg::BE_ALL : acc_be_q;
			rd_beat_q <= 3'h0;
		end else if (bus_en && rd_req_q) begin
			rd_req_q <= 1'b0;
			if (abort_q) begin
				rd_busy_q <= 1'b0;
			end
		end else if (rd_last) begin
			rd_busy_q <= 1'b0;
		end else if (rd_beat_in) begin
			rd_beat_q <= rd_beat_q + 3'h1;
		end
	end
	always_ff @(posedge mclk_i) begin
		if (rd_beat_in) begin
			fill_mem[rd_beat_q] <= bus_if.rd_data;
		end
	end
	// abort follows core reset one cycle late and rides along with a read request still on the link then
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			abort_q <= 1'b0;
		end else begin
			abort_q <= core_reset_i;
		end
	end
	// single read result, unwanted bytes zeroed
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			rd_done_o <= 1'b0;
			rd_word_o <= '0;
		end else begin
			rd_done_o <= rd_last && !rd_line_q;
			if (rd_last && !rd_line_q) begin
				rd_word_o <= bus_if.rd_data & {{8{rd_be_q[3]}}, {8{rd_be_q[2]}},
					{8{rd_be_q[1]}}, {8{rd_be_q[0]}}};
			end
		end
	end
	always_comb begin
		chunk_d = '0;
		for (int j = 0; j < dcbrs_pkg::CHUNK_WORDS; j++) begin
			if (int'(dcbrs_pkg::FILL_CYCLES - fill_cnt_q) * 3 + j < LW) begin
				chunk_d[j*W +: W] = fill_mem[int'(dcbrs_pkg::FILL_CYCLES - fill_cnt_q) * 3 + j];
			end
		end
	end
	// fill copy blocks new reads so the buffer is not overwritten
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			fill_cnt_q    <= 2'h0;
			cache_wr_o    <= 1'b0;
			cache_chunk_o <= 2'h0;
			cache_addr_o  <= '0;
			cache_data_o  <= '0;
		end else if (rd_last && rd_line_q) begin
			fill_cnt_q   <= dcbrs_pkg::FILL_CYCLES;
			cache_addr_o <= {rd_addr_q[W-1:dcbrs_pkg::LINE_OFS_W], 5'h00};
			cache_wr_o   <= 1'b0;
		end else if (fill_cnt_q != 2'h0) begin
			cache_wr_o    <= 1'b1;
			cache_chunk_o <= dcbrs_pkg::FILL_CYCLES - fill_cnt_q;
			cache_data_o  <= chunk_d;
			fill_cnt_q    <= fill_cnt_q - 2'h1;
		end else begin
			cache_wr_o <= 1'b0;
		end
	end
	assign bus_if.rd_req  = rd_req_q;
	assign bus_if.rd_line = rd_line_q;
	assign bus_if.rd_addr = rd_addr_q;
	assign bus_if.rd_be   = rd_be_q;
	assign bus_if.abort   = abort_q;
	assign bus_if.wr_req  = wr_req_q;
	assign bus_if.wr_line = wr_line_q;
	assign bus_if.wr_addr = wr_addr_q;
	assign bus_if.wr_be   = wr_be_q;
	assign bus_if.wr_data = wr_data_q;
endmodule : dcbrs_dcu_end

// File: dcbrs_if.sv
`timescale 1ns/1ps
interface dcbrs_if;
	logic                           bus_en;
	logic                           rd_req;
	logic                           rd_line;
	logic [dcbrs_pkg::WORD_W-1:0]   rd_addr;
	logic [dcbrs_pkg::BE_W-1:0]     rd_be;
	logic                           abort;
	logic                           rd_dval;
	logic [dcbrs_pkg::WORD_W-1:0]   rd_data;
	logic                           wr_req;
	logic                           wr_line;
	logic [dcbrs_pkg::WORD_W-1:0]   wr_addr;
	logic [dcbrs_pkg::BE_W-1:0]     wr_be;
	logic [dcbrs_pkg::WORD_W-1:0]   wr_data;

	modport dcu (
		input  bus_en, rd_dval, rd_data,
		output rd_req, rd_line, rd_addr, rd_be, abort,
		output wr_req, wr_line, wr_addr, wr_be, wr_data
	);
	modport biu (
		output bus_en, rd_dval, rd_data,
		input  rd_req, rd_line, rd_addr, rd_be, abort,
		input  wr_req, wr_line, wr_addr, wr_be, wr_data
	);
endinterface : dcbrs_if

// File: dcbrs_pkg.sv
package dcbrs_pkg;
	localparam int         WORD_W      = 32;
	localparam int         BE_W        = 4;
	localparam int         LINE_WORDS  = 8;
	localparam int         LINE_BITS   = WORD_W * LINE_WORDS;
	localparam int         LINE_OFS_W  = 5;
	localparam int         CHUNK_WORDS = 3;
	localparam int         CHUNK_BITS  = WORD_W * CHUNK_WORDS;
	localparam logic [2:0] LAST_BEAT   = 3'h7;
	localparam logic [3:0] BE_ALL      = 4'hf;
	// line copy from fill buffer to cache, in core cycles
	localparam logic [1:0] FILL_CYCLES = 2'h3;
	// flush work before its line write may be requested, in core cycles
	localparam logic [1:0] FLUSH_PREP  = 2'h2;
	localparam logic [1:0] FLUSH_DEPTH = 2'h2;
	// bus to core clock ratio, 1 to 3; zero reads as 1
	localparam int         RATIO_W     = 2;
endpackage : dcbrs_pkg

// File: dcbrs_sva.sv
`timescale 1ns/1ps
module dcbrs_sva (
	// clock and reset
	input wire logic                          mclk_i,
	input wire logic                          rst_n_i,
	// link signals
	input wire logic                          bus_en,
	input wire logic                          rd_req,
	input wire logic                          rd_line,
	input wire logic                          abort,
	input wire logic                          rd_dval,
	input wire logic                          wr_req,
	input wire logic                          wr_line,
	input wire logic [dcbrs_pkg::WORD_W-1:0]  wr_addr
);
	logic [3:0]  rd_left_q;
	logic [3:0]  wr_left_q;
	logic        gap_q;
	logic [26:0] base_q;

	// beats still owed by the bus unit
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) rd_left_q <= 4'h0;
		else if (bus_en && rd_req && !abort) rd_left_q <= rd_line ? 4'h8 : 4'h1;
		else if (bus_en && rd_left_q != 4'h0) rd_left_q <= rd_left_q - 4'h1;
	end
	// seven beats plus the idle bus cycle after them
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) wr_left_q <= 4'h0;
		else if (bus_en && wr_req) wr_left_q <= wr_line ? 4'h8 : 4'h0;
		else if (bus_en && wr_left_q != 4'h0) wr_left_q <= wr_left_q - 4'h1;
	end
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) gap_q <= 1'b0;
		else if (bus_en) gap_q <= rd_req || wr_req;
	end
	always_ff @(posedge mclk_i) begin
		if (bus_en && wr_req) base_q <= wr_addr[31:5];
	end

	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!rst_n_i);

	req_spacing_a: assert property (bus_en && gap_q |-> !rd_req && !wr_req)
		else $error("request in the bus cycle after a taken one");
	wr_single_a: assert property (bus_en && wr_left_q != 4'h0 |-> !wr_req)
		else $error("write request while a write is running");
	wr_base_a: assert property (bus_en && wr_left_q > 4'h1 |-> wr_addr[31:5] == base_q)
		else $error("line write left its line");
	wr_first_a: assert property (bus_en && wr_req && wr_line |-> wr_addr[4:0] == 5'h00)
		else $error("line write not starting at word zero");
	rd_beats_a: assert property (bus_en |-> rd_dval == (rd_left_q != 4'h0))
		else $error("read beat count or timing off");
	rd_single_a: assert property (bus_en && rd_left_q != 4'h0 |-> !rd_req)
		else $error("second read while one is outstanding");
	abort_drop_a: assert property (bus_en && rd_req && abort |=> !rd_dval [*8])
		else $error("data returned for an aborted read");
	req_hold_a: assert property (!bus_en |=> $stable(rd_req) && $stable(wr_req))
		else $error("request changed inside a bus cycle");

	rd_behind_wr_c: cover property (bus_en && rd_req && wr_left_q != 4'h0);
	overlap_c: cover property (bus_en && rd_dval && wr_left_q > 4'h1);
	abort_c: cover property (bus_en && rd_req && abort);
endmodule : dcbrs_sva
